/* File: design/csd_params.svh */
// Register offsets, field positions, reset values for the channel scan block
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (7-bit address)
// ----------------------------------------------------------------------
`define CSD_ADDR_SCAN 7'h20
`define CSD_ADDR_BGCAL 7'h21
`define CSD_ADDR_AUX 7'h22
`define CSD_ADDR_INCFG_BASE 7'h23
`define CSD_ADDR_DIAG 7'h2A
`define CSD_ADDR_THLD 7'h2B
`define CSD_ADDR_STAT 7'h2C
`define CSD_ADDR_HI_LSB 4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSD_SCAN_MODE_LSB 6
`define CSD_SCAN_LAST_LSB 3
`define CSD_SCAN_FIRST_LSB 0
`define CSD_INCFG_BURN_BIT 7
`define CSD_DIAG_SHORT_BIT 7
`define CSD_DIAG_RAIL_BIT 6
`define CSD_DIAG_POR_BIT 5
`define CSD_DIAG_OVR_LSB 3
`define CSD_DIAG_CH_LSB 0
`define CSD_STAT_PEND_BIT 0
`define CSD_STAT_STBY_BIT 1

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define CSD_SCAN_RST 8'h00
`define CSD_BGCAL_RST 2'h0
`define CSD_AUX_RST 4'h0
`define CSD_THLD_RST 8'h00
`define CSD_EXC_MAX_CODE 4'h9

`endif

/* File: design/csd_pkg.sv */
// Types shared by the channel scan and diagnostics block
`default_nettype none
package csd_pkg;
    typedef enum logic [1:0] {
        single_channel_continuous,
        multi_channel_single_pass,
        multi_channel_continuous,
        multi_channel_with_burnout
    } csd_scan_e;

    typedef enum logic [1:0] {
        bgcal_off,
        bgcal_offset_corr_gain_est,
        bgcal_offset_gain_corr,
        bgcal_offset_gain_est
    } csd_bgcal_e;

    typedef enum logic [1:0] {
        csd_st_standby,
        csd_st_launch,
        csd_st_convert
    } csd_state_e;

    typedef enum logic [1:0] {
        ovr_normal,
        ovr_above_fs,
        ovr_mod_pos,
        ovr_mod_neg
    } csd_ovr_e;
endpackage

`default_nettype wire

/* File: design/csd_top.sv */
// Channel scan sequencer and sensor diagnostic flags
//
// Operation
// - Four scan modes; scan control also holds first and last channel.
// - Scan control writes go to shadow, move to active at conversion start.
// - Shadow ignores writes until transferred; software polls pending bit.
// - Mode zero converts the first scan channel forever.
// - Mode one converts first to last once, then goes to standby.
// - Mode two converts first to last and repeats forever.
// - Mode three scans like two; burnout only after channel's conversion.
// - Burnout available in all modes, gated by per-channel enable.
// - Modes zero to two inject into every enabled channel.
// - Mode three injects into last sampled channel, advancing cyclically.
// - Excitation select sets sources 100uA to 1000uA in 100uA steps.
// - Short flag set when result magnitude within threshold register.
// - Near rail flag set when sampled channel within 50mV of rail.
// - Power-on flag set by reset event, cleared by diag read.
// - Over-range code: 0 normal, 1 above FS, 2 positive, 3 negative.
// - Three-bit result channel names the channel of the shown result.
// - Result of previous conversion shown while next one converts.
// - Seven-bit address splits into high [6:4] and low [3:0].
// - Background calibration select offers four modes zero to three.
`timescale 1ns/1ps
`default_nettype none
`include "csd_params.svh"

module csd_top
    import csd_pkg::*;
#(
    parameter int NUM_CH = 7
) (
    input wire logic clk_sys,                 // System clock, 40 MHz
    input wire logic nrst,                    // Async reset, active low
    input wire logic reg_wr_en,               // Register write strobe
    input wire logic reg_rd_en,               // Register read strobe
    input wire logic [6:0] reg_addr,          // Register address
    input wire logic [7:0] reg_wdata,         // Write data
    output logic [7:0] reg_rdata,             // Read data, next cycle
    input wire logic conv_done,               // Conversion finished pulse
    input wire logic [15:0] res_code,         // Signed result code
    input wire logic res_near_rail,           // Sampled input near a rail
    input wire logic res_over_fs,             // Input beyond full scale
    input wire logic res_ovr_pos,             // Modulator over-range, pos
    input wire logic res_ovr_neg,             // Modulator over-range, neg
    input wire logic por_event,               // Power-on reset event pulse
    output logic conv_start,                  // Conversion start pulse
    output logic [2:0] conv_ch,               // Channel being converted
    output logic converting,                  // Conversion in progress
    output logic standby,                     // Scan stopped
    output logic scan_update_pending,         // Shadow awaits transfer
    output logic [NUM_CH-1:0] burnout_inject, // Burnout current per channel
    output logic [3:0] exc_step,              // Excitation in 100uA steps
    output csd_bgcal_e bgcal_mode             // Background calibration mode
);

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] csd_next_ch(input logic [2:0] cur,
            input logic [2:0] first, input logic [2:0] last,
            input csd_scan_e mode);
        if (mode == single_channel_continuous || cur == last)
            return first;
        return cur + 3'h1;
    endfunction

    function automatic logic [16:0] csd_abs(input logic [15:0] v);
        if (v[15])
            return 17'h00000 - {1'b1, v};
        return {1'b0, v};
    endfunction

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [2:0] addr_high_part;
    logic [3:0] addr_low_part;
    logic [2:0] incfg_idx;
    logic incfg_hit;

    assign addr_high_part = reg_addr[6:`CSD_ADDR_HI_LSB];
    assign addr_low_part = reg_addr[`CSD_ADDR_HI_LSB-1:0];
    assign incfg_idx = 3'(reg_addr - `CSD_ADDR_INCFG_BASE);
    assign incfg_hit = (reg_addr >= `CSD_ADDR_INCFG_BASE) &&
        (int'(incfg_idx) < NUM_CH) && (reg_addr < `CSD_ADDR_DIAG);

    function automatic logic csd_hit(input logic [2:0] hi,
            input logic [3:0] lo, input logic [6:0] target);
        return {hi, lo} == target;
    endfunction

    logic wr_scan;
    logic rd_diag;
    assign wr_scan = reg_wr_en && csd_hit(addr_high_part, addr_low_part,
        `CSD_ADDR_SCAN);
    assign rd_diag = reg_rd_en && csd_hit(addr_high_part, addr_low_part,
        `CSD_ADDR_DIAG);

    // ------------------------------------------------------------------
    // Scan control, shadow and active copies
    // ------------------------------------------------------------------
    logic [7:0] shadow_q;
    logic [7:0] active_q;
    logic pend_q;
    csd_state_e state_q;
    csd_scan_e act_mode;
    logic [2:0] act_first;
    logic [2:0] act_last;

    assign act_mode = csd_scan_e'(active_q[`CSD_SCAN_MODE_LSB +: 2]);
    assign act_first = active_q[`CSD_SCAN_FIRST_LSB +: 3];
    assign act_last = active_q[`CSD_SCAN_LAST_LSB +: 3];

    // Pending blocks rewrites so the sequencer never sees a torn update
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            shadow_q <= `CSD_SCAN_RST;
        end else if (wr_scan && !pend_q) begin
            shadow_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pend_q <= 1'b0;
        end else if (state_q == csd_st_launch && pend_q) begin
            pend_q <= 1'b0;
        end else if (wr_scan) begin
            pend_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            active_q <= `CSD_SCAN_RST;
        end else if (state_q == csd_st_launch && pend_q) begin
            active_q <= shadow_q;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    logic [2:0] ch_q;
    logic start_q;
    logic last_of_pass;

    assign last_of_pass = (act_mode == multi_channel_single_pass) &&
        (ch_q == act_last);

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= csd_st_launch;
        end else begin
            unique case (state_q)
                csd_st_standby: begin
                    if (pend_q)
                        state_q <= csd_st_launch;
                end
                csd_st_launch: begin
                    state_q <= csd_st_convert;
                end
                csd_st_convert: begin
                    if (conv_done && last_of_pass && !pend_q)
                        state_q <= csd_st_standby;
                    else if (conv_done)
                        state_q <= csd_st_launch;
                end
            endcase
        end
    end

    // A fresh configuration restarts the scan at its first channel
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ch_q <= 3'h0;
        end else if (state_q == csd_st_launch) begin
            if (pend_q)
                ch_q <= shadow_q[`CSD_SCAN_FIRST_LSB +: 3];
            else
                ch_q <= csd_next_ch(ch_q, act_first, act_last,
                    act_mode);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q)
            start_q <= 1'b0;
        else
            start_q <= (state_q == csd_st_launch);
    end

    assign conv_start = start_q;
    assign conv_ch = ch_q;
    assign converting = (state_q == csd_st_convert);
    assign standby = (state_q == csd_st_standby);
    assign scan_update_pending = pend_q;

    // ------------------------------------------------------------------
    // Per-channel config, burnout
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] burn_en_q;
    logic [2:0] burn_ch_q;
    logic burn_vld_q;
    logic [NUM_CH-1:0] burn_onehot;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q)
            burn_en_q <= '0;
        else if (reg_wr_en && incfg_hit)
            burn_en_q[incfg_idx] <= reg_wdata[`CSD_INCFG_BURN_BIT];
    end

    // Target is the channel that just finished sampling
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            burn_ch_q <= 3'h0;
            burn_vld_q <= 1'b0;
        end else if (converting && conv_done) begin
            burn_ch_q <= ch_q;
            burn_vld_q <= 1'b1;
        end
    end

    always_comb begin
        burn_onehot = '0;
        if (int'(burn_ch_q) < NUM_CH)
            burn_onehot[burn_ch_q] = burn_vld_q;
        if (!standby && int'(ch_q) < NUM_CH)
            burn_onehot[ch_q] = 1'b0;
    end

    // Outside mode three the injection overlaps the conversion by design
    assign burnout_inject = (act_mode == multi_channel_with_burnout) ?
        (burn_onehot & burn_en_q) : burn_en_q;

    // ------------------------------------------------------------------
    // Auxiliary and calibration settings
    // ------------------------------------------------------------------
    logic [3:0] exc_sel_q;
    logic [1:0] bgcal_q;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            exc_sel_q <= `CSD_AUX_RST;
            bgcal_q <= `CSD_BGCAL_RST;
        end else if (reg_wr_en) begin
            if (reg_addr == `CSD_ADDR_AUX)
                exc_sel_q <= reg_wdata[3:0];
            if (reg_addr == `CSD_ADDR_BGCAL)
                bgcal_q <= reg_wdata[1:0];
        end
    end

    // Codes above the top step clamp to 1000uA
    assign exc_step = ((exc_sel_q > `CSD_EXC_MAX_CODE) ?
        `CSD_EXC_MAX_CODE : exc_sel_q) + 4'h1;
    assign bgcal_mode = csd_bgcal_e'(bgcal_q);

    // ------------------------------------------------------------------
    // Diagnostic flags
    // ------------------------------------------------------------------
    logic [7:0] thld_q;
    logic short_q;
    logic rail_q;
    logic por_q;
    csd_ovr_e ovr_q;
    logic [2:0] res_ch_q;
    csd_ovr_e ovr_d;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q)
            thld_q <= `CSD_THLD_RST;
        else if (reg_wr_en && reg_addr == `CSD_ADDR_THLD)
            thld_q <= reg_wdata;
    end

    always_comb begin
        if (res_ovr_pos)
            ovr_d = ovr_mod_pos;
        else if (res_ovr_neg)
            ovr_d = ovr_mod_neg;
        else if (res_over_fs)
            ovr_d = ovr_above_fs;
        else
            ovr_d = ovr_normal;
    end

    // Held through the next conversion, so software reads the prior one
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            short_q <= 1'b0;
            rail_q <= 1'b0;
            ovr_q <= ovr_normal;
            res_ch_q <= 3'h0;
        end else if (converting && conv_done) begin
            short_q <= csd_abs(res_code) <= {9'h000, thld_q};
            rail_q <= res_near_rail;
            ovr_q <= ovr_d;
            res_ch_q <= ch_q;
        end
    end

    // Power-on flag: event wins over the read that would clear it
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q)
            por_q <= 1'b1;
        else if (por_event)
            por_q <= 1'b1;
        else if (rd_diag)
            por_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    logic [7:0] rd_d;

    always_comb begin
        rd_d = 8'h00;
        if (incfg_hit)
            rd_d[`CSD_INCFG_BURN_BIT] = burn_en_q[incfg_idx];
        unique case (reg_addr)
            `CSD_ADDR_SCAN: rd_d = shadow_q;
            `CSD_ADDR_BGCAL: rd_d = {6'h00, bgcal_q};
            `CSD_ADDR_AUX: rd_d = {4'h0, exc_sel_q};
            `CSD_ADDR_DIAG: rd_d = {short_q, rail_q, por_q, ovr_q, res_ch_q};
            `CSD_ADDR_THLD: rd_d = thld_q;
            `CSD_ADDR_STAT: rd_d = {6'h00, standby, pend_q};
            default: ;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q)
            reg_rdata <= 8'h00;
        else if (reg_rd_en)
            reg_rdata <= rd_d;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n_q);

    sequence s_pass_end;
        converting && conv_done && !pend_q;
    endsequence
    sequence s_relaunch_first;
        (state_q == csd_st_launch) ##1 (conv_start && conv_ch == act_first);
    endsequence

    a_shadow_locked: assert property (pend_q && state_q != csd_st_launch
        |=> $stable(shadow_q)) else $error("shadow changed");
    a_shadow_xfer: assert property (state_q == csd_st_launch && pend_q
        |=> active_q == $past(shadow_q) && !pend_q)
        else $error("no transfer");
    a_mode0_fixed: assert property (conv_start &&
        act_mode == single_channel_continuous |-> conv_ch == act_first)
        else $error("mode0 channel");
    a_pass_stop: assert property (s_pass_end and
        (act_mode == multi_channel_single_pass && ch_q == act_last)
        |=> standby[*2]) else $error("no standby");
    a_scan_wrap: assert property (s_pass_end and
        (act_mode == multi_channel_continuous && ch_q == act_last)
        |=> s_relaunch_first) else $error("no wrap");
    a_burn_apart: assert property (converting &&
        act_mode == multi_channel_with_burnout |-> !burnout_inject[ch_q])
        else $error("burnout overlap");
    a_burn_gated: assert property ((burnout_inject & ~burn_en_q) == '0)
        else $error("burnout ungated");
    a_burn_all: assert property (act_mode != multi_channel_with_burnout
        |-> burnout_inject == burn_en_q) else $error("burnout");
    a_short_flag: assert property (converting && conv_done |=>
        short_q == (csd_abs($past(res_code)) <= {9'h000, $past(thld_q)}))
        else $error("short flag");
    a_por_sticky: assert property (por_event |=> por_q)
        else $error("por lost");
    a_ovr_pos: assert property (converting && conv_done && res_ovr_pos
        |=> ovr_q == ovr_mod_pos) else $error("ovr code");
    a_result_chan: assert property (converting && conv_done
        |=> res_ch_q == $past(ch_q) ##1 $stable(res_ch_q))
        else $error("result channel");

endmodule // csd_top

`default_nettype wire

/* File: dv/csd_sensor_model.sv */
// Behavioural conversion path standing in for the sensors and modulator
`timescale 1ns/1ps
`default_nettype none

module csd_sensor_model #(
    parameter int CONV_CYC = 20
) (
    input wire logic clk_sys,         // System clock
    input wire logic nrst,            // Reset, active low
    input wire logic conv_start,      // Conversion launch pulse
    input wire logic [15:0] set_code, // Result to report next
    input wire logic [3:0] set_flags, // Rail, full scale, pos, neg
    output logic conv_done,           // Conversion finished pulse
    output logic [15:0] res_code,     // Result code
    output logic res_near_rail,       // Near a rail
    output logic res_over_fs,         // Beyond full scale
    output logic res_ovr_pos,         // Modulator over-range, pos
    output logic res_ovr_neg          // Modulator over-range, neg
);
    int cnt;

    // ------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------
    // Outside the done cycle the result lines toggle, so a design
    // sampling them late never sees a stale but plausible value
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt = 0;
            conv_done <= 1'b0;
            res_code <= 16'h0000;
            {res_near_rail, res_over_fs, res_ovr_pos, res_ovr_neg} <= 4'h0;
        end else begin
            conv_done <= 1'b0;
            res_code <= ~res_code;
            {res_near_rail, res_over_fs, res_ovr_pos, res_ovr_neg} <=
                ~{res_near_rail, res_over_fs, res_ovr_pos, res_ovr_neg};
            if (conv_start === 1'b1) begin
                cnt = CONV_CYC;
            end else if (cnt > 0) begin
                cnt--;
                if (cnt == 0) begin
                    conv_done <= 1'b1;
                    res_code <= set_code;
                    {res_near_rail, res_over_fs, res_ovr_pos, res_ovr_neg} <=
                        set_flags;
                end
            end
        end
    end
endmodule // csd_sensor_model

`default_nettype wire

/* File: dv/test_channel_scan_diagnostics.sv */
// Register-level testbench for the channel scan and diagnostics block
`timescale 1ns/1ps
`default_nettype none

module test_channel_scan_diagnostics;
    import csd_pkg::*;
    logic clk_sys, nrst, reg_wr_en, reg_rd_en, por_event;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic conv_done, res_near_rail, res_over_fs, res_ovr_pos, res_ovr_neg;
    logic [15:0] res_code, set_code;
    logic [3:0] set_flags, exc_step;
    logic conv_start, converting, standby, scan_update_pending;
    logic [2:0] conv_ch, ch, prev;
    logic [6:0] burnout_inject;
    csd_bgcal_e bgcal_mode;
    int failures, cmp_count;
    logic [15:0] codes [5] = '{16'h0005, 16'hFFFB, 16'hFFFA, 16'h0006,
                               16'h7FFF};
    logic [3:0] flg [5] = '{4'h0, 4'h8, 4'h4, 4'h6, 4'h1};
    logic [7:0] dexp [5] = '{8'h85, 8'hC5, 8'h0D, 8'h15, 8'h1D};

    csd_top #(.NUM_CH(7)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done),
        .res_code(res_code), .res_near_rail(res_near_rail),
        .res_over_fs(res_over_fs), .res_ovr_pos(res_ovr_pos),
        .res_ovr_neg(res_ovr_neg), .por_event(por_event),
        .conv_start(conv_start), .conv_ch(conv_ch), .converting(converting),
        .standby(standby), .scan_update_pending(scan_update_pending),
        .burnout_inject(burnout_inject), .exc_step(exc_step),
        .bgcal_mode(bgcal_mode));

    csd_sensor_model #(.CONV_CYC(20)) sensor_u (.clk_sys(clk_sys),
        .nrst(nrst), .conv_start(conv_start), .set_code(set_code),
        .set_flags(set_flags), .conv_done(conv_done), .res_code(res_code),
        .res_near_rail(res_near_rail), .res_over_fs(res_over_fs),
        .res_ovr_pos(res_ovr_pos), .res_ovr_neg(res_ovr_neg));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Access and checking tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timeout(input string what);
        failures++;
        $display("[FAIL] %s expected event seen none", what);
        tally_and_finish();
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk_sys) #1;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(posedge clk_sys) #1;
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        @(posedge clk_sys) #1;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge clk_sys) #1;
        reg_rd_en = 1'b0;
        v = reg_rdata;
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        check("reg_rdata", e, v);
    endtask

    // Bounded wait: 0 for pending clear, 1 for standby, 2 for done
    task automatic wait_sel(input int sel);
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge clk_sys) #1;
            if (sel == 0 && scan_update_pending === 1'b0) break;
            if (sel == 1 && standby === 1'b1) break;
            if (sel == 2 && conv_done === 1'b1) break;
        end
        if (i == 300) timeout("status level");
    endtask

    task automatic wait_start(output logic [2:0] c);
        int i;
        // Mid-cycle sampling: the start pulse is settled there
        for (i = 0; i < 200; i++) begin
            @(negedge clk_sys);
            if (conv_start === 1'b1) break;
        end
        if (i == 200) timeout("conv_start");
        c = conv_ch;
    endtask

    task automatic scan_chk(input logic [2:0] f, input logic [2:0] l,
                            input int n);
        logic [2:0] c;
        for (int k = 0; k < n; k++) begin
            wait_start(c);
            check("conv_ch", {5'h00, f + 3'(k % (l - f + 1))}, {5'h00, c});
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, reg_wr_en, reg_rd_en, por_event} = 4'h0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        set_code = 16'h0000;
        set_flags = 4'h0;
        repeat (8) @(posedge clk_sys);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(7'h2A, d);
        check("por flag", 8'h20, d & 8'h20);
        rd(7'h2A, d);
        check("por flag", 8'h00, d & 8'h20);
        // Power-on event landing on the same edge as the clearing read
        @(posedge clk_sys) #1;
        {por_event, reg_rd_en} = 2'b11;
        reg_addr = 7'h2A;
        @(posedge clk_sys) #1;
        {por_event, reg_rd_en} = 2'b00;
        rd(7'h2A, d);
        check("por flag", 8'h20, d & 8'h20);
        rd_chk(7'h20, 8'h00);
        rd_chk(7'h2B, 8'h00);
        rd_chk(7'h7F, 8'h00);
        check("exc_step", 8'h01, {4'h0, exc_step});
        scan_chk(3'h0, 3'h0, 3);
        for (int v = 0; v < 12; v++) begin
            wr(7'h22, 8'(v));
            check("exc_step", (v > 9) ? 8'h0A : 8'(v + 1),
                  {4'h0, exc_step});
        end
        for (int v = 0; v < 4; v++) begin
            wr(7'h21, 8'(v));
            check("bgcal_mode", 8'(v), {6'h00, bgcal_mode});
        end
        wr(7'h3B, 8'h33);
        wr(7'h2B, 8'h05);
        rd_chk(7'h2B, 8'h05);
        // Writes synced to a start so the shadow is still held
        wait_start(ch);
        wr(7'h20, 8'h99);
        rd_chk(7'h2C, 8'h01);
        wr(7'h20, 8'h00);
        rd_chk(7'h20, 8'h99);
        wait_sel(0);
        scan_chk(3'h1, 3'h3, 5);
        wait_start(ch);
        wr(7'h20, 8'h62);
        wait_sel(0);
        scan_chk(3'h2, 3'h4, 3);
        wait_sel(1);
        rd_chk(7'h2C, 8'h02);
        check("converting", 8'h00, {7'h00, converting});
        wr(7'h24, 8'h80);
        wr(7'h25, 8'h80);
        wr(7'h20, 8'hD1);
        wait_sel(0);
        scan_chk(3'h1, 3'h2, 2);
        #1 check("burnout", 8'h02, {1'b0, burnout_inject});
        scan_chk(3'h1, 3'h1, 1);
        #1 check("burnout", 8'h04, {1'b0, burnout_inject});
        wait_start(prev);
        wr(7'h25, 8'h00);
        wr(7'h20, 8'h05);
        wait_sel(0);
        scan_chk(3'h5, 3'h5, 1);
        #1 check("burnout", 8'h02, {1'b0, burnout_inject});
        rd(7'h2A, d);
        check("result ch", {5'h00, prev}, d & 8'h07);
        for (int i = 0; i < 5; i++) begin
            set_code = codes[i];
            set_flags = flg[i];
            wait_sel(2);
            rd(7'h2A, d);
            check("diag flags", dexp[i], d);
            check("result ch", 8'h05, d & 8'h07);
        end
        tally_and_finish();
    end
endmodule // test_channel_scan_diagnostics

`default_nettype wire
